// >>> logic/ptp_port.sv
// Summary of operation
// [R1] Accept flag high when ready, plain output.
// [R2] Sender strobe is level or pulse >=250ns.
// [R3] Input strobe edge follows polarity option.
// [R4] Rising strobe waits 150ns before loading.
// [R5] Accept flag drops 150ns after strobe; on a falling strobe the code drops it at load, one clock after the edge.
// [R6] Sender holds data 100ns after flag.
// [R7] Fast senders must wait for accept flag.
// [R8] Input inhibits block bus and keyboard.
// [R9] Low inhibit stops keyboard to screen.
// [R10] Low inhibit stops keyboard to output.
// [R11] Data inverted unless bypass option fitted.
// [R12] Seven data bits on separate buses.
// [R13] Output data driven only when selected.
// [R14] Act on acknowledge trailing edge, hold data.
// [R15] Acknowledge polarity set by option.
// [R16] Output strobe when data stable and requested.
// [R17] Data removed 100ns after request drops.
// [R18] Service request low while character waits.
// [R19] Tri-state ready driven when selected, polarity option.
// [R20] Tri-state ready clears within 150ns.
// [R21] Receiver acknowledges each taken character.
// [R22] Single bus joins lines; select external.
// [R23] Data accepted pulse raises accept flag.
// [R24] Ignore strobes while busy; hold output.
`include "ptp_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ptp_port (
   input wire logic core_clk,
   input wire logic rst,
   input wire ptp_pkg::ptp_opts_s opts,
   input wire ptp_pkg::ptp_inhibit_s inhibits,
   input wire logic in_strobe,
   input wire ptp_pkg::ptp_char_t in_data,
   input wire logic kbd_strobe,
   input wire ptp_pkg::ptp_char_t kbd_data,
   input wire logic data_accepted,
   input wire logic src_valid,
   input wire ptp_pkg::ptp_char_t src_data,
   input wire logic xmit_select,
   input wire logic out_ack,
   output logic input_accept_flag,
   output ptp_pkg::ptp_char_t term_data,
   output logic term_strobe,
   output logic src_taken,
   output ptp_pkg::ptp_char_t out_data,
   output logic out_data_oe,
   output logic out_strobe,
   output logic svc_req_o,
   output logic svc_req_oe,
   output logic out_rdy_ts,
   output logic out_rdy_oe
);

   ////////////////////////////////////////////////////////////////////////
   function automatic ptp_pkg::ptp_char_t conv(input ptp_pkg::ptp_char_t d,
                                               input logic bypass);
      conv = bypass ? d : ~d; // see [R11]
   endfunction

   function automatic logic to_active(input logic lvl, input logic pos);
      to_active = pos ? lvl : ~lvl;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   function automatic logic count_done(input logic [`PTP_CNT_W-1:0] cnt, input int cyc);
      count_done = (cnt == `PTP_CNT_W'(cyc - 1));
   endfunction

   function automatic logic [`PTP_CNT_W-1:0] count_step(input logic [`PTP_CNT_W-1:0] cnt);
      count_step = cnt + `PTP_CNT_W'(1);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Input strobe and output acknowledge edge detection
   logic strb_q;
   logic strb_armed_q;
   logic kbd_q;
   logic ack_q;
   logic strb_act;
   logic ack_act;
   logic bus_edge;
   logic kbd_edge;
   logic in_blocked;

   assign strb_act = to_active(in_strobe, opts.strobe_pos_option); // see [R3]
   assign ack_act = to_active(out_ack, opts.ack_pos_option); // see [R15]
   // First cycle after reset only learns the idle level, so no false edge
   assign bus_edge = strb_act & ~strb_q & strb_armed_q;
   assign kbd_edge = kbd_strobe & ~kbd_q;
   assign in_blocked = ~inhibits.input_off_n | inhibits.input_off_hi; // see [R8]

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strb_q <= 1'b0;
         strb_armed_q <= 1'b0;
      end else begin
         strb_q <= strb_act;
         strb_armed_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         kbd_q <= 1'b0;
      end else begin
         kbd_q <= kbd_strobe;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Input path
   ptp_pkg::ptp_in_state_e in_st_q;
   ptp_pkg::ptp_in_state_e in_st_d;
   logic [`PTP_CNT_W-1:0] in_cnt_q;
   logic take_bus;
   logic take_kbd;
   logic load_bus;
   logic drop_flag;

   // Strobes are ignored unless ready, see [R24]
   assign take_bus = (in_st_q == ptp_pkg::PTP_IN_READY) & ~in_blocked & bus_edge;
   assign take_kbd = (in_st_q == ptp_pkg::PTP_IN_READY) & ~in_blocked & ~bus_edge
                     & kbd_edge & inhibits.kbd_to_screen_n; // see [R9]
   // Negative strobes load without the settle delay
   assign load_bus = (in_st_q == ptp_pkg::PTP_IN_SETTLE)
                     & (~opts.strobe_pos_option | count_done(in_cnt_q, `PTP_SETTLE_CYC)); // see [R4]
   assign drop_flag = (in_st_q == ptp_pkg::PTP_IN_SETTLE)
                      & count_done(in_cnt_q, `PTP_FLAG_DROP_CYC); // see [R5]

   always_comb begin
      in_st_d = in_st_q;
      case (in_st_q)
         ptp_pkg::PTP_IN_READY: begin
            if (take_bus) begin
               in_st_d = ptp_pkg::PTP_IN_SETTLE;
            end else if (take_kbd) begin
               in_st_d = ptp_pkg::PTP_IN_WAIT_ACC;
            end
         end
         ptp_pkg::PTP_IN_SETTLE: begin
            if (load_bus) begin
               in_st_d = ptp_pkg::PTP_IN_WAIT_ACC;
            end
         end
         ptp_pkg::PTP_IN_WAIT_ACC: begin
            if (data_accepted) begin
               in_st_d = ptp_pkg::PTP_IN_READY; // see [R23]
            end
         end
         default: begin
            in_st_d = ptp_pkg::PTP_IN_READY;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_st_q <= ptp_pkg::PTP_IN_READY;
      end else begin
         in_st_q <= in_st_d;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         in_cnt_q <= '0;
      end else if (take_bus) begin
         in_cnt_q <= '0;
      end else if (in_st_q == ptp_pkg::PTP_IN_SETTLE) begin
         in_cnt_q <= count_step(in_cnt_q);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         input_accept_flag <= 1'b1;
      end else if (take_kbd || load_bus || drop_flag) begin
         input_accept_flag <= 1'b0; // see [R1] [R5]
      end else if (in_st_q == ptp_pkg::PTP_IN_WAIT_ACC && data_accepted) begin
         input_accept_flag <= 1'b1; // see [R23]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         term_data <= '0;
      end else if (take_kbd) begin
         term_data <= kbd_data;
      end else if (load_bus) begin
         term_data <= conv(in_data, opts.inversion_bypass_option); // see [R12]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         term_strobe <= 1'b0;
      end else begin
         term_strobe <= take_kbd | load_bus;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Output path
   ptp_pkg::ptp_out_state_e out_st_q;
   ptp_pkg::ptp_out_state_e out_st_d;
   logic [`PTP_CNT_W-1:0] out_cnt_q;
   logic sel_act;
   logic ack_fall;
   logic kbd_out_ok;
   logic char_load;
   logic strobe_set;
   logic strobe_clr;
   logic out_clear;

   assign sel_act = opts.xmit_sel_high_option ? xmit_select : ~xmit_select; // see [R13]
   assign ack_fall = ack_q & ~ack_act; // see [R14]
   assign kbd_out_ok = kbd_edge & inhibits.kbd_to_output_n & ~in_blocked; // see [R10]
   // Character stays latched until acknowledged, see [R24]
   assign char_load = (out_st_q == ptp_pkg::PTP_OUT_EMPTY)
                      & (kbd_out_ok | src_valid);
   assign strobe_set = (out_st_q == ptp_pkg::PTP_OUT_FULL) & ack_q; // see [R16]
   assign strobe_clr = (out_st_q == ptp_pkg::PTP_OUT_STROBED) & ack_fall; // see [R14]
   assign out_clear = (out_st_q == ptp_pkg::PTP_OUT_REMOVE)
                      & count_done(out_cnt_q, `PTP_OUT_HOLD_CYC); // see [R17]

   always_comb begin
      out_st_d = out_st_q;
      case (out_st_q)
         ptp_pkg::PTP_OUT_EMPTY: begin
            if (char_load) begin
               out_st_d = ptp_pkg::PTP_OUT_FULL;
            end
         end
         ptp_pkg::PTP_OUT_FULL: begin
            if (strobe_set) begin
               out_st_d = ptp_pkg::PTP_OUT_STROBED;
            end
         end
         ptp_pkg::PTP_OUT_STROBED: begin
            if (strobe_clr) begin
               out_st_d = ptp_pkg::PTP_OUT_REMOVE;
            end
         end
         ptp_pkg::PTP_OUT_REMOVE: begin
            if (out_clear) begin
               out_st_d = ptp_pkg::PTP_OUT_EMPTY;
            end
         end
         default: begin
            out_st_d = ptp_pkg::PTP_OUT_EMPTY;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_st_q <= ptp_pkg::PTP_OUT_EMPTY;
      end else begin
         out_st_q <= out_st_d;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_cnt_q <= '0;
      end else if (strobe_clr) begin
         out_cnt_q <= '0;
      end else if (out_st_q == ptp_pkg::PTP_OUT_REMOVE) begin
         out_cnt_q <= count_step(out_cnt_q);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_data <= '0;
      end else if (char_load) begin
         out_data <= conv(kbd_out_ok ? kbd_data : src_data,
                          opts.inversion_bypass_option);
      end else if (out_clear) begin
         out_data <= '0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_strobe <= 1'b0;
      end else if (strobe_set) begin
         out_strobe <= 1'b1;
      end else if (strobe_clr) begin
         out_strobe <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         src_taken <= 1'b0;
      end else begin
         src_taken <= char_load & ~kbd_out_ok;
      end
   end

   // Open-drain request only ever pulls low
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         svc_req_o <= 1'b0;
      end else begin
         svc_req_o <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         svc_req_oe <= 1'b0;
      end else if (char_load) begin
         svc_req_oe <= 1'b1; // see [R18]
      end else if (strobe_clr) begin
         svc_req_oe <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers; tri-state ready clears on the cycle after the trailing edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_data_oe <= 1'b0;
         out_rdy_oe <= 1'b0;
      end else begin
         out_data_oe <= sel_act; // see [R13] [R22]
         out_rdy_oe <= sel_act; // see [R19]
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         out_rdy_ts <= 1'b0;
      end else if (ack_fall || out_st_q == ptp_pkg::PTP_OUT_REMOVE
                   || out_st_q == ptp_pkg::PTP_OUT_EMPTY) begin
         out_rdy_ts <= ~opts.ready_polarity_option; // see [R20]
      end else begin
         out_rdy_ts <= opts.ready_polarity_option; // see [R19]
      end
   end

endmodule

`default_nettype wire

// >>> common/ptp_defines.svh
`ifndef PTP_DEFINES_SVH
`define PTP_DEFINES_SVH

`define PTP_CLK_PERIOD_NS 10
`define PTP_DATA_W 7
// Settling delay after a rising input strobe
`define PTP_SETTLE_NS 150
`define PTP_SETTLE_CYC ((`PTP_SETTLE_NS + `PTP_CLK_PERIOD_NS - 1) / `PTP_CLK_PERIOD_NS)
// Accept flag drop after strobe leading edge
`define PTP_FLAG_DROP_NS 150
`define PTP_FLAG_DROP_CYC ((`PTP_FLAG_DROP_NS + `PTP_CLK_PERIOD_NS - 1) / `PTP_CLK_PERIOD_NS)
// Output character removal after request released
`define PTP_OUT_HOLD_NS 100
`define PTP_OUT_HOLD_CYC ((`PTP_OUT_HOLD_NS + `PTP_CLK_PERIOD_NS - 1) / `PTP_CLK_PERIOD_NS)
// Tri-state ready clears within this time (longest, round down)
`define PTP_RDY_CLR_NS 150
`define PTP_RDY_CLR_CYC (`PTP_RDY_CLR_NS / `PTP_CLK_PERIOD_NS)
`define PTP_CNT_W 5

`endif

// >>> common/ptp_pkg.sv
package ptp_pkg;
   typedef logic [6:0] ptp_char_t;

   typedef struct packed {
      logic inversion_bypass_option;
      logic strobe_pos_option;
      logic ack_pos_option;
      logic ready_polarity_option;
      logic xmit_sel_high_option;
   } ptp_opts_s;

   typedef struct packed {
      logic input_off_n;
      logic input_off_hi;
      logic kbd_to_screen_n;
      logic kbd_to_output_n;
   } ptp_inhibit_s;

   typedef enum logic [1:0] {
      PTP_IN_READY,
      PTP_IN_SETTLE,
      PTP_IN_WAIT_ACC
   } ptp_in_state_e;

   typedef enum logic [1:0] {
      PTP_OUT_EMPTY,
      PTP_OUT_FULL,
      PTP_OUT_STROBED,
      PTP_OUT_REMOVE
   } ptp_out_state_e;
endpackage

// >>> verif/ptp_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_port_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire ptp_pkg::ptp_opts_s opts,
   input wire ptp_pkg::ptp_inhibit_s inhibits,
   input wire logic in_strobe,
   input wire logic data_accepted,
   input wire logic xmit_select,
   input wire logic out_ack,
   input wire logic input_accept_flag,
   input wire ptp_pkg::ptp_char_t out_data,
   input wire logic out_data_oe,
   input wire logic out_strobe,
   input wire logic svc_req_oe,
   input wire logic out_rdy_ts,
   input wire logic out_rdy_oe
);
   wire logic busy = !input_accept_flag;
   wire logic go = input_accept_flag && inhibits.input_off_n && !inhibits.input_off_hi;
   wire logic ack = out_ack == opts.ack_pos_option;
   wire logic sel = xmit_select == opts.xmit_sel_high_option;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_req;
      svc_req_oe && ack && !out_strobe;
   endsequence
   sequence s_rise;
      opts.strobe_pos_option && $rose(in_strobe) && go;
   endsequence
   a_rise_flag_drop: assert property (s_rise |-> !busy[*8] ##[5:9] busy)
      else $error("flag drop after rising strobe off");
   a_fall_flag_drop: assert property (
      !opts.strobe_pos_option && $fell(in_strobe) && go |-> ##[1:2] busy)
      else $error("flag drop after falling strobe off");
   a_accept_rise: assert property (busy && data_accepted |=> !busy)
      else $error("flag not raised by accept pulse");
   a_ack_strobe: assert property (s_req |-> ##[1:3] out_strobe)
      else $error("no output strobe after request");
   a_data_hold: assert property ($fell(out_strobe) |-> $stable(out_data)[*8])
      else $error("output char moved early");
   a_svc_hold: assert property (svc_req_oe && !ack && !out_strobe |=> svc_req_oe)
      else $error("service request dropped early");
   a_sel_enable: assert property (
      1'b1 |=> {out_data_oe, out_rdy_oe} == {2{$past(sel)}})
      else $error("output enables do not follow select");
   a_ready_clear: assert property (
      $fell(ack) && out_strobe |-> ##[0:15] out_rdy_ts != opts.ready_polarity_option)
      else $error("ready line not cleared in time");
endmodule
`default_nettype wire

// >>> verif/ptp_rcv_model.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_rcv_model (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ack_pos,
   input wire logic slow,
   input wire logic svc_req_oe,
   input wire logic out_strobe,
   output logic out_ack
);
   logic act_q;
   logic [5:0] cnt_q;
   assign out_ack = act_q ~^ ack_pos;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         act_q <= 1'b0;
         cnt_q <= 6'h00;
      end else if (!act_q && svc_req_oe && cnt_q >= (slow ? 6'h28 : 6'h0C)) begin
         act_q <= 1'b1;
         cnt_q <= 6'h00;
      end else if (act_q && out_strobe && cnt_q >= 6'h19) begin
         act_q <= 1'b0;
         cnt_q <= 6'h00;
      end else if (cnt_q != 6'h3F) begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
endmodule
`default_nettype wire

// >>> verif/ptp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_port_test;
   logic core_clk = 1'b0, rst = 1'b1, in_strobe = 1'b0, kbd_strobe = 1'b0;
   logic data_accepted = 1'b0, src_valid = 1'b0, xmit_select = 1'b1, slow = 1'b0;
   ptp_pkg::ptp_opts_s opts = 5'h00;
   ptp_pkg::ptp_inhibit_s inhibits = 4'hB;
   ptp_pkg::ptp_char_t in_data = 7'h00, kbd_data = 7'h00, src_data = 7'h00;
   ptp_pkg::ptp_char_t term_data, out_data, last_term, last_out, c, p, e;
   logic input_accept_flag, term_strobe, src_taken, out_data_oe, out_strobe, svc_req_o;
   logic svc_req_oe, out_rdy_ts, out_rdy_oe, out_ack, ostr_q, svc_seen;
   int num_errors = 0, total_checks = 0, n_term = 0, n_out = 0, n_tk = 0, n0, n1;
   logic [15:0] seed = 16'hE24C;
   always #5 core_clk = ~core_clk;
   ptp_port ptp_port_i (.*);
   ptp_rcv_model ptp_rcv_model_i (.core_clk, .rst, .ack_pos(opts.ack_pos_option), .slow,
      .svc_req_oe, .out_strobe, .out_ack);
   always @(posedge core_clk) begin
      ostr_q <= out_strobe;
      if (term_strobe === 1'b1) begin
         n_term <= n_term + 1;
         last_term <= term_data;
      end
      if (out_strobe === 1'b1 && ostr_q !== 1'b1) begin
         n_out <= n_out + 1;
         last_out <= out_data;
         svc_seen <= svc_req_oe;
      end
      if (src_taken === 1'b1) n_tk <= n_tk + 1;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic ptp_pkg::ptp_char_t on_bus(input ptp_pkg::ptp_char_t v);
      return opts.inversion_bypass_option ? v : ~v;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic check_char(input ptp_pkg::ptp_char_t got, input ptp_pkg::ptp_char_t exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors=%0d checks=%0d", num_errors, total_checks);
      if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wait_for(ref int cnt, input int old, input int lim);
      for (int i = 0; i < lim && cnt == old; i++) @(posedge core_clk);
      if (cnt == old) begin
         num_errors++;
         finish_test();
      end
   endtask
   // Strobe held well beyond the minimum width, data held past the flag drop
   task automatic send_in(input ptp_pkg::ptp_char_t v);
      tick(1);
      in_strobe <= ~opts.strobe_pos_option;
      in_data <= on_bus(v);
      tick(3);
      in_strobe <= opts.strobe_pos_option;
      tick(30);
   endtask
   task automatic accept();
      tick(1);
      data_accepted <= 1'b1;
      tick(1);
      data_accepted <= 1'b0;
      tick(1);
   endtask
   initial begin
      tick(12);
      rst <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         tick(1);
         opts.strobe_pos_option <= ~k[1];
         opts.inversion_bypass_option <= k[0];
         seed = lfsr(seed);
         c = seed[6:0];
         n0 = n_term;
         send_in(c);
         #1 check_char(last_term, c);
         check_flag(input_accept_flag, 1'b0);
         send_in(~c);
         #1 check_flag(n_term == n0 + 1, 1'b1);
         accept();
         #1 check_flag(input_accept_flag, 1'b1);
      end
      for (int j = 0; j < 4; j++) begin
         tick(1);
         inhibits <= j[1] ? {2'h2, j[0], ~j[0]} : {j[0], j[0], 2'h3};
         seed = lfsr(seed);
         c = seed[6:0];
         p = last_term;
         n0 = n_term;
         n1 = n_out;
         if (j[1]) kbd_data <= c;
         if (j[1]) kbd_strobe <= 1'b1;
         else send_in(c);
         tick(90);
         kbd_strobe <= 1'b0;
         #1 check_flag(n_term == n0 + (j == 3), 1'b1);
         check_flag(n_out == n1 + (j == 2), 1'b1);
         e = j == 2 ? on_bus(c) : (j == 3 ? c : p);
         check_char(j == 2 ? last_out : last_term, e);
         accept();
      end
      for (int k = 0; k < 4; k++) begin
         tick(1);
         opts.ack_pos_option <= k[0];
         opts.xmit_sel_high_option <= k[1];
         opts.ready_polarity_option <= k[0] ^ k[1];
         slow <= k[1];
         seed = lfsr(seed);
         c = seed[6:0];
         xmit_select <= seed[7];
         src_valid <= 1'b1;
         src_data <= c;
         n0 = n_tk;
         n1 = n_out;
         wait_for(n_tk, n0, 20);
         src_valid <= 1'b0;
         #1 check_flag(out_rdy_ts, opts.ready_polarity_option);
         check_flag(svc_req_o, 1'b0);
         wait_for(n_out, n1, 200);
         #1 check_char(last_out, on_bus(c));
         check_flag(svc_seen, 1'b1);
         check_flag(out_data_oe, xmit_select ~^ opts.xmit_sel_high_option);
         check_flag(out_rdy_oe, xmit_select ~^ opts.xmit_sel_high_option);
         tick(60);
         #1 check_flag(out_rdy_ts, ~opts.ready_polarity_option);
         check_char(out_data, 7'h00);
      end
      finish_test();
   end
endmodule
bind ptp_port ptp_port_checker ptp_port_checker_i (.*);
`default_nettype wire
